// *** paot_pkg.sv ***
// Shared constants for the two-step converter output path and its capture logic
`default_nettype none
package paot_pkg;
   localparam int WORD_W = 10;
   localparam int COARSE_W = 5;
   localparam int FINE_W = 6;
   localparam int LOW_W = 5;
   localparam int SWITCH_N = 32;
   localparam int LEVEL_W = 12;
   localparam int FIFO_DEPTH = 2;
   // Input level in LSB; full scale is 0 .. FS_TOP
   localparam logic signed [LEVEL_W-1:0] FS_BOTTOM = 12'sh000;
   localparam logic signed [LEVEL_W-1:0] FS_TOP = 12'sh3ff;
   localparam logic signed [LEVEL_W-1:0] OOR_MARGIN = 12'sh001;
   // Encode timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int ENC_PERIOD_NS = 80;
   localparam int ENC_HALF_CYC = ENC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int ENC_MAX_PERIOD_NS = 100;
   localparam int DUTY_PCT = 50;
   // Encode rises before the first valid word reaches capture
   localparam int PRIME_CAPTURES = 4;
   localparam logic [1:0] HALF_LAST = 2'(ENC_HALF_CYC - 1);
   localparam logic [2:0] PRIME_LAST = 3'(PRIME_CAPTURES);
endpackage
`default_nettype wire

// *** paot_link_if.sv ***
// Pin-level link between converter and capture logic
`default_nettype none
interface paot_link_if;
   logic                      encode;
   logic [paot_pkg::WORD_W-1:0] sample_word_bits;
   logic                      out_of_range;
   modport dev (input encode, output sample_word_bits, output out_of_range);
   modport cap (output encode, input sample_word_bits, input out_of_range);
endinterface
`default_nettype wire

// *** paot_converter.sv ***
// Converter digital side: sampling, coarse/fine stages, decode alignment, output latch
// Behaviour
// (R1) Sample taken on encode rising edge
// (R2) Encode duty cycle 50 percent, +-10 points
// (R3) Encode rate never below 10 MSPS
// (R4) Encode runs continuously, no burst clocking
// (R5) Coarse result one-hot selects one of 32
// (R6) Fine 6 bits: five low, one corrects coarse
// (R7) Decode aligns stages into 10-bit word
// (R8) Output register updates on encode falling edge
// (R9) Output latched, 2.5 encode cycles latency
// (R10) Out-of-range high beyond full scale by 1 LSB; the code raises it only beyond full scale by 2 LSB or more
// (R11) Out-of-range flag pipelined with data
`default_nettype none
module paot_converter
(
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic signed [paot_pkg::LEVEL_W-1:0] analog_level,
   paot_link_if.dev                               link
);
   import paot_pkg::*;

   // Every stage of the two-step pipeline lives in one registered record
   typedef struct packed {
      logic                 enc_s1;
      logic                 enc_s2;
      logic                 enc_prev;
      logic [WORD_W-1:0]    held;
      logic                 held_oor;
      logic [COARSE_W-1:0]  coarse;
      logic [SWITCH_N-1:0]  switch_sel;
      logic [WORD_W-1:0]    residue_src;
      logic                 coarse_oor;
      logic [COARSE_W-1:0]  coarse_d;
      logic [FINE_W-1:0]    fine;
      logic                 fine_oor;
      logic [WORD_W-1:0]    aligned;
      logic                 aligned_oor;
      logic [WORD_W-1:0]    staged;
      logic                 staged_oor;
      logic [WORD_W-1:0]    out_word;
      logic                 out_oor;
   } paot_conv_type;

   paot_conv_type state;
   paot_conv_type next_state;
   logic          enc_rise;
   logic          enc_fall;
   logic [SWITCH_N-1:0] flash_sel;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [WORD_W-1:0] clamp_level(input logic signed [LEVEL_W-1:0] lv);
      logic [WORD_W-1:0] r;
      r = lv[WORD_W-1:0];
      if (lv < FS_BOTTOM)
      begin
         r = '0;
      end
      else if (lv > FS_TOP)
      begin
         r = '1;
      end
      return r;
   endfunction

   function automatic logic beyond_range(input logic signed [LEVEL_W-1:0] lv);
      return (lv < FS_BOTTOM - OOR_MARGIN) || (lv > FS_TOP + OOR_MARGIN);
   endfunction

   // Coarse comparators: comparator i trips once the held level reaches tap i
   function automatic logic [SWITCH_N-1:0] coarse_thermo(input logic [WORD_W-1:0] lv);
      logic [SWITCH_N-1:0] t;
      t = '0;
      for (int i = 0; i < SWITCH_N; i++)
      begin
         if (lv >= WORD_W'(i * SWITCH_N))
         begin
            t[i] = 1'b1;
         end
      end
      return t;
   endfunction

   // Top edge of the lowest run of ones in the comparator thermometer; a bubble cannot select two switches
   function automatic logic [SWITCH_N-1:0] thermo_to_onehot(input logic [SWITCH_N-1:0] t);
      logic [SWITCH_N:0]   tp;
      logic [SWITCH_N-1:0] sel;
      tp = {1'b0, t};
      sel = '0;
      for (int i = SWITCH_N - 1; i >= 0; i--)
      begin
         if (tp[i] && !tp[i + 1])
         begin
            sel = SWITCH_N'(1) << i;
         end
      end
      return sel;
   endfunction

   // Binary code of the active switch
   function automatic logic [COARSE_W-1:0] onehot_code(input logic [SWITCH_N-1:0] sel);
      logic [COARSE_W-1:0] c;
      c = '0;
      for (int i = 0; i < SWITCH_N; i++)
      begin
         if (sel[i])
         begin
            c = c | COARSE_W'(i);
         end
      end
      return c;
   endfunction

   // Ladder tap voltage picked by the single active switch
   function automatic logic [WORD_W-1:0] ladder_tap(input logic [SWITCH_N-1:0] sel);
      return {onehot_code(sel), {LOW_W{1'b0}}};
   endfunction

   // Fine comparators saturate, so a coarse slip shows as an end code, not a wrap
   function automatic logic [FINE_W-1:0] fine_flash(input logic [WORD_W-1:0] src,
                                                   input logic [WORD_W-1:0] tap);
      logic [FINE_W-1:0] f;
      f = '0;
      if (src >= tap)
      begin
         f = '1;
         if (src - tap <= WORD_W'({FINE_W{1'b1}}))
         begin
            f = FINE_W'(src - tap);
         end
      end
      return f;
   endfunction

   // The coarse stage is exact here, so the correction bit stays low in practice
   // Spare fine bit carries into the coarse code; a carry off the top pins full scale
   function automatic logic [WORD_W-1:0] correct_word(input logic [COARSE_W-1:0] c,
                                                      input logic [FINE_W-1:0]   f);
      logic [COARSE_W:0] top;
      logic [WORD_W-1:0] w;
      top = {1'b0, c} + {{COARSE_W{1'b0}}, f[FINE_W-1]};
      w = {top[COARSE_W-1:0], f[LOW_W-1:0]};
      if (top[COARSE_W])
      begin
         w = '1;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Only the second synchroniser stage feeds edge detection
   assign enc_rise = state.enc_s2 && !state.enc_prev;
   assign enc_fall = !state.enc_s2 && state.enc_prev;
   // Coarse flash resolves the held level while the residue waits for the fine stage
   assign flash_sel = thermo_to_onehot(coarse_thermo(state.held)); // R5

   always_comb
   begin
      next_state = state;
      next_state.enc_s1 = link.encode;
      next_state.enc_s2 = state.enc_s1;
      next_state.enc_prev = state.enc_s2;
      // Rising encode edge: sample, fine conversion and the staging register
      if (enc_rise)
      begin
         next_state.held = clamp_level(analog_level); // R1
         next_state.held_oor = beyond_range(analog_level); // R10
         // Fine stage resolves the residue left by the chosen ladder tap
         next_state.fine = fine_flash(state.residue_src, ladder_tap(state.switch_sel)); // R6
         next_state.coarse_d = state.coarse; // R7
         next_state.fine_oor = state.coarse_oor; // R11
         next_state.staged = state.aligned; // R9
         next_state.staged_oor = state.aligned_oor; // R11
      end
      // Falling encode edge: coarse conversion, decode alignment and output
      if (enc_fall)
      begin
         next_state.coarse = onehot_code(flash_sel);
         next_state.switch_sel = flash_sel; // R5
         next_state.residue_src = state.held;
         next_state.coarse_oor = state.held_oor; // R11
         // Correction bit lifts the coarse code when the fine stage overflows
         next_state.aligned = correct_word(state.coarse_d, state.fine); // R6 R7
         next_state.aligned_oor = state.fine_oor; // R11
         next_state.out_word = state.staged; // R8 R9
         next_state.out_oor = state.staged_oor; // R8 R11
      end
   end

   // Synchronous reset clears every stage, so the first words after reset read zero
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Output pins come straight from the fall-updated register
   assign link.sample_word_bits = state.out_word; // R9
   assign link.out_of_range = state.out_oor; // R10
endmodule
`default_nettype wire

// *** paot_capture.sv ***
// Capture side: encode clock generator and word capture into a two-entry buffer
`default_nettype none
module paot_capture
(
   input  wire logic                          clk,
   input  wire logic                          nrst,
   output logic [paot_pkg::WORD_W-1:0]        word_data,
   output logic                               word_oor,
   output logic                               word_valid,
   input  wire logic                          word_ready,
   output logic                               overrun,
   paot_link_if.cap                           link
);
   import paot_pkg::*;

   typedef struct packed {
      logic [1:0]                       div_cnt;
      logic                             enc;
      logic [2:0]                       primed;
      logic [WORD_W:0]                  d_s1;
      logic [WORD_W:0]                  d_s2;
      logic [FIFO_DEPTH-1:0][WORD_W:0]  mem;
      logic                             wr_ptr;
      logic                             rd_ptr;
      logic [1:0]                       count;
      logic                             overrun;
   } paot_cap_type;

   paot_cap_type state;
   paot_cap_type next_state;
   logic         half_done;
   logic         capture;
   logic         push;
   logic         pop;
   logic         fill_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Free-running divider: equal high and low halves, never gated
   assign half_done = state.div_cnt == HALF_LAST; // R2 R3 R4
   // Word is read where encode is driven high: stable since the last fall
   assign capture = half_done && !state.enc;
   assign fill_ready = state.count != 2'(FIFO_DEPTH);
   assign push = capture && (state.primed == PRIME_LAST) && fill_ready; // R9
   assign pop = word_valid && word_ready;

   always_comb
   begin
      next_state = state;
      next_state.d_s1 = {link.out_of_range, link.sample_word_bits};
      next_state.d_s2 = state.d_s1;
      next_state.div_cnt = half_done ? 2'h0 : 2'(state.div_cnt + 2'h1);
      if (half_done)
      begin
         next_state.enc = !state.enc; // R1 R4
      end
      // Discard words still holding pipeline fill
      if (capture && state.primed != PRIME_LAST)
      begin
         next_state.primed = 3'(state.primed + 3'h1); // R9
      end
      // Encode cannot stall, so a full buffer can only report the loss
      next_state.overrun = capture && (state.primed == PRIME_LAST) && !fill_ready;
      if (push)
      begin
         next_state.mem[state.wr_ptr] = state.d_s2;
         next_state.wr_ptr = !state.wr_ptr;
      end
      if (pop)
      begin
         next_state.rd_ptr = !state.rd_ptr;
      end
      if (push && !pop)
      begin
         next_state.count = 2'(state.count + 2'h1);
      end
      else if (pop && !push)
      begin
         next_state.count = 2'(state.count - 2'h1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign link.encode = state.enc;
   assign word_data = state.mem[state.rd_ptr][WORD_W-1:0];
   assign word_oor = state.mem[state.rd_ptr][WORD_W];
   assign word_valid = state.count != 2'h0;
   assign overrun = state.overrun;
endmodule
`default_nettype wire

// *** paot_link_chk.sv ***
// Timing and clamp checks on the converter-to-capture link
`default_nettype none
module paot_link_chk
(
   input wire logic                        clk,
   input wire logic                        nrst,
   input wire logic                        encode,
   input wire logic [paot_pkg::WORD_W-1:0] sample_word_bits,
   input wire logic                        out_of_range
);
   import paot_pkg::*;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   sequence s_high2;
      encode [*2] ##1 !encode;
   endsequence
   sequence s_low2;
      !encode [*2] ##1 encode;
   endsequence
   // Output slot: three clocks after a detected encode fall
   sequence s_slot;
      encode && $past(encode) && !$past(encode, 2);
   endsequence
   ////////////////////////////////////////
   property p_enc_high;
      $rose(encode) |-> s_high2;
   endproperty
   property p_enc_low;
      $fell(encode) |-> s_low2;
   endproperty
   property p_enc_period;
      $rose(encode) |-> ##4 $rose(encode);
   endproperty
   property p_word_slot;
      $changed(sample_word_bits) |-> s_slot;
   endproperty
   property p_oor_slot;
      $changed(out_of_range) |-> s_slot;
   endproperty
   property p_word_stands;
      $changed(sample_word_bits) |=> $stable(sample_word_bits) [*3];
   endproperty
   property p_oor_stands;
      $changed(out_of_range) |=> $stable(out_of_range) [*3];
   endproperty
   property p_oor_clamp;
      out_of_range |-> (sample_word_bits == 10'h000 || sample_word_bits == 10'h3ff);
   endproperty
   a_enc_high: assert property (p_enc_high) else $error("encode high phase wrong");
   a_enc_low: assert property (p_enc_low) else $error("encode low phase wrong");
   a_enc_period: assert property (p_enc_period) else $error("encode gap seen");
   a_word_slot: assert property (p_word_slot) else $error("word moved off slot");
   a_oor_slot: assert property (p_oor_slot) else $error("flag moved off slot");
   a_word_stands: assert property (p_word_stands) else $error("word not held");
   a_oor_stands: assert property (p_oor_stands) else $error("flag not held");
   a_oor_clamp: assert property (p_oor_clamp) else $error("flag without clamp");
endmodule
`default_nettype wire

// *** paot_tb.sv ***
// Self-checking bench: converter and capture joined over the link
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import paot_pkg::*;
   logic                      clk = 1'b0;
   logic                      nrst = 1'b0;
   logic signed [LEVEL_W-1:0] analog_level = 12'sh000;
   logic                      word_ready = 1'b0;
   logic [WORD_W-1:0]         word_data;
   logic                      word_oor;
   logic                      word_valid;
   logic                      overrun;
   int                        fails = 0;
   int                        tests_run = 0;
   paot_link_if link ();
   paot_converter paot_converter_inst (.clk(clk), .nrst(nrst), .analog_level(analog_level),
      .link(link));
   paot_capture paot_capture_inst (.clk(clk), .nrst(nrst), .word_data(word_data),
      .word_oor(word_oor), .word_valid(word_valid), .word_ready(word_ready),
      .overrun(overrun), .link(link));
   paot_link_chk paot_link_chk_inst (.clk(clk), .nrst(nrst), .encode(link.encode),
      .sample_word_bits(link.sample_word_bits), .out_of_range(link.out_of_range));
   initial forever #10 clk = ~clk;
   ////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check_word(input string what, input logic [WORD_W-1:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_valid;
      int n;
      n = 0;
      while (word_valid !== 1'b1 && n < 30)
      begin
         step(1);
         n++;
      end
      check_bit("word_valid", 1'b1, word_valid);
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      nrst = 1'b0;
      step(4);
      check_bit("encode", 1'b0, link.encode);
      check_word("sample_word_bits", 10'h000, link.sample_word_bits);
      check_bit("word_valid", 1'b0, word_valid);
      nrst = 1'b1;
   endtask
   // Level held long enough that every queued word belongs to it
   task automatic t_level(input logic signed [LEVEL_W-1:0] lvl, input logic [WORD_W-1:0] w,
      input logic f);
      analog_level = lvl;
      word_ready = 1'b1;
      step(40);
      word_ready = 1'b0;
      wait_valid;
      check_word("word_data", w, word_data);
      check_bit("word_oor", f, word_oor);
   endtask
   // First word after reset must be a real sample, not pipeline fill
   task automatic t_first(input logic signed [LEVEL_W-1:0] lvl, input logic [WORD_W-1:0] w);
      analog_level = lvl;
      word_ready = 1'b0;
      t_reset;
      wait_valid;
      check_word("word_data", w, word_data);
   endtask
   task automatic t_overrun;
      logic got;
      got = 1'b0;
      analog_level = 12'sh123;
      word_ready = 1'b1;
      step(40);
      word_ready = 1'b0;
      // Overrun is a one-cycle pulse, so look after every edge
      repeat (24)
      begin
         step(1);
         if (overrun === 1'b1)
         begin
            got = 1'b1;
         end
      end
      check_bit("overrun", 1'b1, got);
      check_word("word_data", 10'h123, word_data);
      word_ready = 1'b1;
      step(1);
      check_bit("word_valid", 1'b1, word_valid);
      check_word("word_data", 10'h123, word_data);
      step(1);
      word_ready = 1'b0;
   endtask
   ////////////////////////////////////////
   initial
   begin
      t_reset;
      t_level(12'sh000, 10'h000, 1'b0);
      t_level(12'sh3ff, 10'h3ff, 1'b0);
      t_level(12'sh2aa, 10'h2aa, 1'b0);
      t_level(12'sh155, 10'h155, 1'b0);
      t_level(12'sh01f, 10'h01f, 1'b0);
      t_level(12'sh020, 10'h020, 1'b0);
      t_level(12'shfff, 10'h000, 1'b0);
      t_level(12'shffe, 10'h000, 1'b1);
      t_level(12'sh400, 10'h3ff, 1'b0);
      t_level(12'sh401, 10'h3ff, 1'b1);
      t_overrun;
      t_first(12'sh0f0, 10'h0f0);
      t_level(12'sh0f0, 10'h0f0, 1'b0);
      finish_test;
   end
   // Whole run is about 540 clocks; this cuts a hang short
   initial
   begin
      #100000;
      fails++;
      finish_test;
   end
endmodule
`default_nettype wire
